// File: hdl/lcdcps_pkg.sv
package lcdcps_pkg;

   // ----------------------------------------------------------------
   // Bus and register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W             = 12;
   localparam int          DATA_W             = 32;
   localparam logic [9:0]  LCD_CONTROL_INDEX  = 10'h0B1;
   localparam logic [9:0]  LCD_STATUS_INDEX   = 10'h0B2;
   localparam logic [1:0]  RESP_OKAY          = 2'h0;
   localparam logic [1:0]  RESP_SLVERR        = 2'h2;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int          DISPLAY_ON_BIT     = 7;
   localparam int          CLOCK_SELECT_BIT   = 6;
   localparam int          FRAME_RATE_LSB     = 4;
   localparam int          DUTY_SELECT_BIT    = 3;
   localparam int          SPLIT_LSB          = 0;
   localparam logic [7:0]  LCD_CONTROL_RESET  = 8'h2F;

   // ----------------------------------------------------------------
   // Split codes and timing
   // ----------------------------------------------------------------
   localparam logic [2:0]  SPLIT_ALL_IO       = 3'h0;
   localparam logic [2:0]  SPLIT_ALL_SEGMENT  = 3'h7;
   localparam logic [5:0]  FAST_RC_DIV_LAST   = 6'h3F;
   localparam logic [3:0]  FRAME_DIV_RATE0    = 4'h8;
   localparam logic [3:0]  FRAME_DIV_RATE1    = 4'h4;
   localparam logic [3:0]  FRAME_DIV_RATE2    = 4'h2;
   localparam logic [3:0]  FRAME_DIV_RATE3    = 4'h1;
   localparam logic [1:0]  LAST_COM_THIRD     = 2'h2;
   localparam logic [1:0]  LAST_COM_QUARTER   = 2'h3;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_RESP = 1'b1
   } lcdcps_bus_e;

endpackage : lcdcps_pkg

// File: hdl/lcdcps_frame_if.sv
`timescale 1ns/1ps
interface lcdcps_frame_if;
   logic       enable;
   logic       clock_select;
   logic [1:0] frame_rate;
   logic       duty;
   logic [1:0] com_index;
   logic       polarity;

   modport ctl (output enable, output clock_select, output frame_rate, output duty,
                input com_index, input polarity);
   modport gen (input enable, input clock_select, input frame_rate, input duty,
                output com_index, output polarity);
endinterface : lcdcps_frame_if

// File: hdl/lcdcps_frame_gen.sv
`timescale 1ns/1ps
module lcdcps_frame_gen (
   input  wire logic   sys_clk,
   input  wire logic   reset,
   input  wire logic   clk_en,
   input  wire logic   slow_crystal_clock,
   input  wire logic   fast_rc_clock,
   lcdcps_frame_if.gen frm
);

   logic       slow_prev;
   logic       fast_prev;
   logic [5:0] fast_cnt;
   logic [3:0] phase_cnt;
   logic [1:0] com_index;
   logic       polarity;
   logic       next_slow_prev;
   logic       next_fast_prev;
   logic [5:0] next_fast_cnt;
   logic [3:0] next_phase_cnt;
   logic [1:0] next_com_index;
   logic       next_polarity;
   logic       src_tick;
   logic [3:0] phase_last;
   logic [1:0] com_last;

   localparam logic [3:0] FRAME_DIV_RATE0_M1 = lcdcps_pkg::FRAME_DIV_RATE0 - 4'h1;
   localparam logic [3:0] FRAME_DIV_RATE1_M1 = lcdcps_pkg::FRAME_DIV_RATE1 - 4'h1;
   localparam logic [3:0] FRAME_DIV_RATE2_M1 = lcdcps_pkg::FRAME_DIV_RATE2 - 4'h1;
   localparam logic [3:0] FRAME_DIV_RATE3_M1 = lcdcps_pkg::FRAME_DIV_RATE3 - 4'h1;

   // ----------------------------------------------------------------
   // Source select, rate divider, common sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_slow_prev = slow_crystal_clock;
      next_fast_prev = fast_rc_clock;
      next_fast_cnt  = fast_cnt;
      next_phase_cnt = phase_cnt;
      next_com_index = com_index;
      next_polarity  = polarity;
      src_tick       = 1'b0;
      case (frm.frame_rate)
         2'h0:    phase_last = FRAME_DIV_RATE0_M1;
         2'h1:    phase_last = FRAME_DIV_RATE1_M1;
         2'h2:    phase_last = FRAME_DIV_RATE2_M1;
         default: phase_last = FRAME_DIV_RATE3_M1;
      endcase
      com_last = frm.duty ? lcdcps_pkg::LAST_COM_QUARTER : lcdcps_pkg::LAST_COM_THIRD;
      if (!frm.enable) begin
         next_fast_cnt  = 6'h00;
         next_phase_cnt = 4'h0;
         next_com_index = 2'h0;
         next_polarity  = 1'b0;
      end else begin
         if (fast_rc_clock && !fast_prev) begin
            next_fast_cnt = fast_cnt + 6'h01;
         end
         if (frm.clock_select) begin
            src_tick = fast_rc_clock && !fast_prev
                       && (fast_cnt == lcdcps_pkg::FAST_RC_DIV_LAST);
         end else begin
            src_tick = slow_crystal_clock && !slow_prev;
         end
         if (src_tick) begin
            if (phase_cnt >= phase_last) begin
               next_phase_cnt = 4'h0;
               if (com_index >= com_last) begin
                  next_com_index = 2'h0;
                  next_polarity  = !polarity;
               end else begin
                  next_com_index = com_index + 2'h1;
               end
            end else begin
               next_phase_cnt = phase_cnt + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         slow_prev <= 1'b0;
         fast_prev <= 1'b0;
         fast_cnt  <= 6'h00;
         phase_cnt <= 4'h0;
         com_index <= 2'h0;
         polarity  <= 1'b0;
      end else if (clk_en) begin
         slow_prev <= next_slow_prev;
         fast_prev <= next_fast_prev;
         fast_cnt  <= next_fast_cnt;
         phase_cnt <= next_phase_cnt;
         com_index <= next_com_index;
         polarity  <= next_polarity;
      end
   end

   assign frm.com_index = com_index;
   assign frm.polarity  = polarity;

endmodule : lcdcps_frame_gen

// File: hdl/lcdcps_top.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module lcdcps_top (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        clk_en,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        slow_crystal_clock,
   input  wire logic        fast_rc_clock,
   input  wire logic [7:0]  gpio_out,
   input  wire logic [7:0]  gpio_oe,
   input  wire logic [7:0]  seg_data,
   output logic [7:0]       port0_out,
   output logic [7:0]       port0_oe,
   output logic [3:0]       com_out,
   output logic [3:0]       com_oe
);

   lcdcps_frame_if frm ();

   logic [7:0]              lcd_control;

   lcdcps_pkg::lcdcps_bus_e wr_state;
   lcdcps_pkg::lcdcps_bus_e rd_state;

   logic                    aw_held;
   logic                    w_held;
   logic [11:0]             aw_addr;
   logic [7:0]              w_byte;
   logic                    w_lane;

   logic [7:0]              next_lcd_control;
   lcdcps_pkg::lcdcps_bus_e next_wr_state;
   lcdcps_pkg::lcdcps_bus_e next_rd_state;

   logic                    next_aw_held;
   logic                    next_w_held;
   logic [11:0]             next_aw_addr;
   logic [7:0]              next_w_byte;
   logic                    next_w_lane;

   logic                    next_awready;
   logic                    next_wready;

   logic                    next_bvalid;
   logic [1:0]              next_bresp;

   logic                    next_arready;
   logic                    next_rvalid;
   logic [31:0]             next_rdata;
   logic [1:0]              next_rresp;

   logic [7:0]              seg_mask;

   logic [7:0]              next_port0_out;
   logic [7:0]              next_port0_oe;
   logic [3:0]              next_com_out;
   logic [3:0]              next_com_oe;

   logic [2:0]              split;
   logic                    on;

   // ----------------------------------------------------------------
   // Frame sequencer
   // ----------------------------------------------------------------
   assign frm.enable       = lcd_control[lcdcps_pkg::DISPLAY_ON_BIT];
   assign frm.clock_select = lcd_control[lcdcps_pkg::CLOCK_SELECT_BIT];
   assign frm.frame_rate   = lcd_control[lcdcps_pkg::FRAME_RATE_LSB +: 2];
   assign frm.duty         = lcd_control[lcdcps_pkg::DUTY_SELECT_BIT];

   lcdcps_frame_gen u_frame_gen (
      .sys_clk            (sys_clk),
      .reset              (reset),
      .clk_en             (clk_en),
      .slow_crystal_clock (slow_crystal_clock),
      .fast_rc_clock      (fast_rc_clock),
      .frm                (frm.gen)
   );

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   always_comb begin
      next_lcd_control = lcd_control;
      next_wr_state    = wr_state;
      next_aw_held     = aw_held;
      next_w_held      = w_held;
      next_aw_addr     = aw_addr;
      next_w_byte      = w_byte;
      next_w_lane      = w_lane;
      next_bvalid      = s_axi_bvalid;
      next_bresp       = s_axi_bresp;

      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end

      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_byte = s_axi_wdata[7:0];
         next_w_lane = s_axi_wstrb[0];
      end

      case (wr_state)
         lcdcps_pkg::BUS_IDLE: begin
            if (next_aw_held && next_w_held) begin
               next_aw_held  = 1'b0;
               next_w_held   = 1'b0;
               next_bvalid   = 1'b1;
               next_wr_state = lcdcps_pkg::BUS_RESP;

               if (next_aw_addr[11:2] == lcdcps_pkg::LCD_CONTROL_INDEX) begin
                  next_bresp = lcdcps_pkg::RESP_OKAY;
                  if (next_w_lane) begin
                     next_lcd_control = next_w_byte;
                  end
               end else if (next_aw_addr[11:2] == lcdcps_pkg::LCD_STATUS_INDEX) begin
                  next_bresp = lcdcps_pkg::RESP_OKAY;
               end else begin
                  next_bresp = lcdcps_pkg::RESP_SLVERR;
               end
            end
         end
         lcdcps_pkg::BUS_RESP: begin
            if (s_axi_bready) begin
               next_bvalid   = 1'b0;
               next_wr_state = lcdcps_pkg::BUS_IDLE;
            end
         end
         default: begin
            next_wr_state = lcdcps_pkg::BUS_IDLE;
         end
      endcase

      next_awready = (next_wr_state == lcdcps_pkg::BUS_IDLE) && !next_aw_held;
      next_wready  = (next_wr_state == lcdcps_pkg::BUS_IDLE) && !next_w_held;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         lcd_control   <= lcdcps_pkg::LCD_CONTROL_RESET;
         wr_state      <= lcdcps_pkg::BUS_IDLE;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 12'h000;
         w_byte        <= 8'h00;
         w_lane        <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else if (clk_en) begin
         lcd_control   <= next_lcd_control;
         wr_state      <= next_wr_state;
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         aw_addr       <= next_aw_addr;
         w_byte        <= next_w_byte;
         w_lane        <= next_w_lane;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   always_comb begin
      next_rd_state = rd_state;
      next_arready  = s_axi_arready;
      next_rvalid   = s_axi_rvalid;
      next_rdata    = s_axi_rdata;
      next_rresp    = s_axi_rresp;

      case (rd_state)
         lcdcps_pkg::BUS_IDLE: begin
            next_arready = 1'b1;

            if (s_axi_arvalid && s_axi_arready) begin
               next_arready  = 1'b0;
               next_rvalid   = 1'b1;
               next_rd_state = lcdcps_pkg::BUS_RESP;
               next_rresp    = lcdcps_pkg::RESP_OKAY;

               if (s_axi_araddr[11:2] == lcdcps_pkg::LCD_CONTROL_INDEX) begin
                  next_rdata = {24'h000000, lcd_control};
               end else if (s_axi_araddr[11:2] == lcdcps_pkg::LCD_STATUS_INDEX) begin
                  next_rdata = {28'h0000000, frm.polarity, frm.enable, frm.com_index};
               end else begin
                  next_rdata = 32'h00000000;
                  next_rresp = lcdcps_pkg::RESP_SLVERR;
               end
            end
         end
         lcdcps_pkg::BUS_RESP: begin
            if (s_axi_rready) begin
               next_rvalid   = 1'b0;
               next_arready  = 1'b1;
               next_rd_state = lcdcps_pkg::BUS_IDLE;
            end
         end
         default: begin
            next_rd_state = lcdcps_pkg::BUS_IDLE;
         end
      endcase

   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rd_state      <= lcdcps_pkg::BUS_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'h0;
      end else if (clk_en) begin
         rd_state      <= next_rd_state;
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end

   // ----------------------------------------------------------------
   // Port 0 split and drive levels
   // ----------------------------------------------------------------
   always_comb begin
      split = lcd_control[lcdcps_pkg::SPLIT_LSB +: 3];
      on    = lcd_control[lcdcps_pkg::DISPLAY_ON_BIT];

      case (split)
         lcdcps_pkg::SPLIT_ALL_IO:      seg_mask = 8'h00;
         3'h1:                          seg_mask = 8'hC0;
         3'h2:                          seg_mask = 8'hE0;
         3'h3:                          seg_mask = 8'hF0;
         3'h4:                          seg_mask = 8'hF8;
         3'h5:                          seg_mask = 8'hFC;
         3'h6:                          seg_mask = 8'hFE;
         lcdcps_pkg::SPLIT_ALL_SEGMENT: seg_mask = 8'hFF;
         default:                       seg_mask = 8'hFF;
      endcase

      for (int i = 0; i < 8; i++) begin
         if (seg_mask[i]) begin
            next_port0_oe[i]  = 1'b1;
            next_port0_out[i] = on && (frm.polarity ^ seg_data[i]);
         end else begin
            next_port0_oe[i]  = gpio_oe[i];
            next_port0_out[i] = gpio_out[i];
         end
      end

      for (int c = 0; c < 4; c++) begin
         next_com_oe[c]  = on && ((c < 3) || frm.duty);
         next_com_out[c] = on && ((frm.com_index == c[1:0]) ^ frm.polarity);
      end

   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         port0_out <= 8'h00;
         port0_oe  <= 8'h00;
         com_out   <= 4'h0;
         com_oe    <= 4'h0;
      end else if (clk_en) begin
         port0_out <= next_port0_out;
         port0_oe  <= next_port0_oe;
         com_out   <= next_com_out;
         com_oe    <= next_com_oe;
      end
   end

endmodule : lcdcps_top

// File: dv/lcdcps_chk.sv
`timescale 1ns/1ps
module lcdcps_chk (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        clk_en,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [7:0]  gpio_out,
   input wire logic [7:0]  gpio_oe,
   input wire logic [7:0]  port0_out,
   input wire logic [7:0]  port0_oe,
   input wire logic [3:0]  com_out,
   input wire logic [3:0]  com_oe
);
   // ------------------------------
   // Control shadow and checks
   // ------------------------------
   logic [7:0] shadow;
   logic [7:0] next_shadow;
   logic [7:0] seg_mask;
   always_comb begin
      next_shadow = shadow;
      if (clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
          s_axi_wstrb[0] && s_axi_awaddr == {lcdcps_pkg::LCD_CONTROL_INDEX, 2'h0}) begin
         next_shadow = s_axi_wdata[7:0];
      end
      seg_mask = (shadow[2:0] == 3'h0) ? 8'h00 : 8'hFF << (3'h7 - shadow[2:0]);
   end
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         shadow <= lcdcps_pkg::LCD_CONTROL_RESET;
      end else begin
         shadow <= next_shadow;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence write_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence settled;
      $past(clk_en) && !$past(reset) && $stable(shadow);
   endsequence
   write_answer_a: assert property (write_taken |=> s_axi_bvalid && !s_axi_awready)
      else $error("write response late");
   bresp_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   read_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response late");
   rdata_hold_a: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   io_pins_a: assert property (
      settled |-> (((port0_out ^ $past(gpio_out)) | (port0_oe ^ $past(gpio_oe)))
                   & ~seg_mask) == 8'h00)
      else $error("io pin not following gpio");
   seg_drive_a: assert property (settled |-> (port0_oe & seg_mask) == seg_mask)
      else $error("segment pin not driven");
   blank_segs_a: assert property (
      settled ##0 !shadow[7] |-> (port0_out & seg_mask) == 8'h00)
      else $error("segment pin not blank");
   commons_off_a: assert property (
      (!shadow[7])[*3] |-> com_out == 4'h0 && com_oe == 4'h0)
      else $error("commons driven while off");
   third_duty_a: assert property (settled ##0 (shadow[7] && !shadow[3]) |-> com_oe == 4'h7)
      else $error("third duty commons wrong");
   quarter_duty_a: assert property (settled ##0 (shadow[7] && shadow[3]) |-> com_oe == 4'hF)
      else $error("quarter duty commons wrong");
endmodule : lcdcps_chk

bind lcdcps_top lcdcps_chk u_chk (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .gpio_out(gpio_out), .gpio_oe(gpio_oe), .port0_out(port0_out), .port0_oe(port0_oe),
   .com_out(com_out), .com_oe(com_oe));

// File: dv/lcdcps_glass_model.sv
`timescale 1ns/1ps
module lcdcps_glass_model (
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic [3:0] com_out,
   input  wire logic [3:0] com_oe,
   output int              com_steps
);
   logic [3:0] last_com;
   // Counts common pattern changes seen on driven glass
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         last_com  <= 4'h0;
         com_steps <= 0;
      end else begin
         last_com <= com_out;
         if (com_oe != 4'h0 && com_out != last_com) begin
            com_steps <= com_steps + 1;
         end
      end
   end
endmodule : lcdcps_glass_model

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
   logic        sys_clk, reset, clk_en, slow_crystal_clock, fast_rc_clock;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rnd_state;
   logic [3:0]  s_axi_wstrb, com_out, com_oe;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [7:0]  gpio_out, gpio_oe, seg_data, port0_out, port0_oe;
   logic [33:0] exp_r[$];
   logic [1:0]  exp_b[$];
   int          miscompares, compares, com_steps;
   localparam logic [11:0] CTRL = {lcdcps_pkg::LCD_CONTROL_INDEX, 2'h0};
   localparam logic [1:0]  OK = lcdcps_pkg::RESP_OKAY;
   localparam logic [7:0]  SEG_MASK [8] = '{8'h00, 8'hC0, 8'hE0, 8'hF0,
                                            8'hF8, 8'hFC, 8'hFE, 8'hFF};
   lcdcps_top u_dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .slow_crystal_clock(slow_crystal_clock), .fast_rc_clock(fast_rc_clock),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .seg_data(seg_data), .port0_out(port0_out),
      .port0_oe(port0_oe), .com_out(com_out), .com_oe(com_oe));
   lcdcps_glass_model u_glass (.sys_clk(sys_clk), .reset(reset), .com_out(com_out),
      .com_oe(com_oe), .com_steps(com_steps));
   // ------------------------------
   // Helpers and bus tasks
   // ------------------------------
   function automatic logic [31:0] xorshift();
      rnd_state = rnd_state ^ (rnd_state << 13);
      rnd_state = rnd_state ^ (rnd_state >> 17);
      rnd_state = rnd_state ^ (rnd_state << 5);
      return rnd_state;
   endfunction : xorshift
   task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      if (miscompares == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic give_up(input string name);
      check(name, 34'h1, 34'h0);
      tally_and_finish();
   endtask : give_up
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                            input logic [1:0] resp);
      int n;
      n = 0;
      @(posedge sys_clk);
      exp_b.push_back(resp);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (n > 50) give_up("write_wait");
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask : axi_write
   task automatic axi_read(input logic [11:0] a, input logic [33:0] exp);
      int n;
      n = 0;
      @(posedge sys_clk);
      exp_r.push_back(exp);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (n > 50) give_up("read_wait");
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask : axi_read
   task automatic tick(input int n, input logic fast);
      repeat (n) begin
         slow_crystal_clock <= !fast;
         fast_rc_clock      <= fast;
         repeat (2) @(posedge sys_clk);
         slow_crystal_clock <= 1'b0;
         fast_rc_clock      <= 1'b0;
         repeat (2) @(posedge sys_clk);
      end
      repeat (3) @(posedge sys_clk);
   endtask : tick
   task automatic pins(input logic [7:0] eo, input logic [7:0] ee);
      repeat (3) @(posedge sys_clk);
      check("port0_out", {26'h0, port0_out}, {26'h0, eo});
      check("port0_oe", {26'h0, port0_oe}, {26'h0, ee});
   endtask : pins
   // Result monitor pairs each answer with the oldest note
   always @(posedge sys_clk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         check("read_word", {s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
         check("write_resp", {32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
      end
   end
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      logic [31:0] r;
      int          n0;
      {reset, clk_en, rnd_state} = {2'h3, 32'h533AF34A};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
      {slow_crystal_clock, fast_rc_clock, gpio_out, gpio_oe, seg_data} = 26'h0;
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      axi_read(CTRL, {OK, 32'h2F});
      pins(8'h00, 8'hFF);
      check("com_oe", {30'h0, com_oe}, 34'h0);
      axi_write(12'h000, 32'h0, 4'hF, lcdcps_pkg::RESP_SLVERR);
      axi_read(12'h000, {lcdcps_pkg::RESP_SLVERR, 32'h0});
      r = xorshift();
      axi_write(CTRL, r, 4'hF, OK);
      axi_read(CTRL, {OK, 24'h0, r[7:0]});
      axi_write(CTRL, ~r, 4'hE, OK);
      axi_read(CTRL, {OK, 24'h0, r[7:0]});
      for (int s = 0; s < 8; s++) begin
         r = xorshift();
         gpio_out <= r[7:0];
         gpio_oe  <= r[15:8];
         axi_write(CTRL, {29'h1, s[2:0]}, 4'hF, OK);
         pins(r[7:0] & ~SEG_MASK[s], r[15:8] | SEG_MASK[s]);
      end
      seg_data <= r[23:16];
      axi_write(CTRL, 32'hBC, 4'hF, OK);
      pins((r[23:16] & 8'hF8) | (r[7:0] & 8'h07), r[15:8] | 8'hF8);
      tick(3, 1'b0);
      check("com_out", {30'h0, com_out}, 34'h8);
      tick(1, 1'b0);
      pins((~r[23:16] & 8'hF8) | (r[7:0] & 8'h07), r[15:8] | 8'hF8);
      check("com_out", {30'h0, com_out}, 34'hE);
      axi_write(CTRL, 32'h0F, 4'hF, OK);
      axi_write(CTRL, 32'hB4, 4'hF, OK);
      tick(3, 1'b0);
      check("com_third", {27'h0, com_oe, com_out[2:0]}, {27'h0, 4'h7, 3'h6});
      for (int f = 0; f < 4; f++) begin
         axi_write(CTRL, 32'h0F, 4'hF, OK);
         axi_write(CTRL, 32'h8F | (f << 4), 4'hF, OK);
         tick(0, 1'b0);
         n0 = com_steps;
         tick(16, 1'b0);
         check("frame_steps", 34'(com_steps - n0), 34'(16 >> (3 - f)));
      end
      axi_write(CTRL, 32'h0F, 4'hF, OK);
      axi_write(CTRL, 32'hFF, 4'hF, OK);
      tick(0, 1'b0);
      n0 = com_steps;
      tick(16, 1'b0);
      check("rc_source_idle", 34'(com_steps - n0), 34'h0);
      tick(128, 1'b1);
      check("rc_source_steps", 34'(com_steps - n0), 34'h2);
      clk_en <= 1'b0;
      tick(64, 1'b1);
      clk_en <= 1'b1;
      check("frozen_steps", 34'(com_steps - n0), 34'h2);
      axi_write(CTRL, 32'h3F, 4'hF, OK);
      tick(0, 1'b0);
      n0 = com_steps;
      tick(8, 1'b0);
      check("halted_steps", 34'(com_steps - n0), 34'h0);
      check("com_off", {30'h0, com_out}, 34'h0);
      axi_read({lcdcps_pkg::LCD_STATUS_INDEX, 2'h0}, {OK, 32'h0});
      tally_and_finish();
   end
endmodule : tb
